// *** smb_pkg.sv ***
// constants shared by the charger register target and its bus host
// assumes nothing beyond a systemverilog compiler
package smb_pkg;
	// ----------------------------------------
	// target address and command codes
	// ----------------------------------------
	localparam logic [6:0] TARGET_ADDR = 7'h09;
	localparam logic [7:0] CMD_OPTION = 8'h12;
	localparam logic [7:0] CMD_FILL = 8'h14;
	localparam logic [7:0] CMD_VOLT = 8'h15;
	localparam logic [7:0] CMD_DRAW = 8'h3F;
	localparam logic [7:0] CMD_MAKER = 8'hFE;
	localparam logic [7:0] CMD_PART = 8'hFF;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] RST_OPTION = 16'h7904;
	localparam logic [15:0] RST_FILL = 16'h0000;
	localparam logic [15:0] RST_VOLT = 16'h0000;
	localparam logic [15:0] RST_DRAW = 16'h1000;
	// identification values are arbitrary
	localparam logic [15:0] MAKER_ID_DEF = 16'h5A5A;
	localparam logic [15:0] PART_ID_DEF = 16'h00A5;
	// ----------------------------------------
	// host registers (byte offsets) and fields
	// ----------------------------------------
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_WDATA = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_GO_WR = 0;
	localparam int CTRL_GO_RD = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_RDATA = 16;
	// ----------------------------------------
	// byte framing and timing
	// ----------------------------------------
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam int CLK_SYS_NS = 5;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_SYS_NS);
endpackage

// *** smb_if.sv ***
// open-drain two-wire bus joining the host and the charger target
// assumes both ends drive low only, enables high while driving
`timescale 1ns/1ps
interface smb_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// ----------------------------------------
	// wired-and resolution with pull-ups
	// ----------------------------------------
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport host(output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, input scl, input sda);
	modport dev(output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// *** smb_sync.sv ***
// two flip-flop synchroniser for a group of levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
module smb_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '1;
			q <= '1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// *** smb_target.sv ***
// charger register target: word reads and writes over the two-wire bus
// assumes clk_link runs free and much faster than scl; rst_b async low
`timescale 1ns/1ps
module smb_target import smb_pkg::*; #(
	parameter logic [15:0] MAKER_ID = MAKER_ID_DEF,
	parameter logic [15:0] PART_ID = PART_ID_DEF
) (
	input wire logic clk_link,
	input wire logic rst_b,
	input wire logic power_good,
	smb_if.dev bus,
	output logic [15:0] charger_option_control,
	output logic [15:0] battery_fill_current_setting,
	output logic [15:0] battery_target_voltage_setting,
	output logic [15:0] supply_draw_limit_setting,
	output logic bus_active
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_DLO, ST_DHI, ST_TLO, ST_THI, ST_WAIT
	} smb_stage_e;

	smb_stage_e stage;
	smb_stage_e stage_after;
	logic scl_s;
	logic sda_s;
	logic pg_s;
	logic scl_d;
	logic sda_d;
	logic [3:0] cnt;
	logic [7:0] shreg;
	logic [7:0] cmd;
	logic [7:0] lo_byte;
	logic [15:0] tx_word;
	logic m_ack;
	logic sda_oe;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic ack_fall;
	logic end_fall;
	logic tx_stage;
	logic [7:0] cur_tx;
	logic wr_en;

	// ----------------------------------------
	// read word decode
	// ----------------------------------------
	function automatic logic [15:0] rd_word(input logic [7:0] c, input logic [15:0] opt,
		input logic [15:0] fill, input logic [15:0] volt, input logic [15:0] draw);
		case (c)
			CMD_OPTION: rd_word = opt;
			CMD_FILL: rd_word = fill;
			CMD_VOLT: rd_word = volt;
			CMD_DRAW: rd_word = draw;
			CMD_MAKER: rd_word = MAKER_ID;
			CMD_PART: rd_word = PART_ID;
			default: rd_word = 16'h0000;
		endcase
	endfunction

	// ----------------------------------------
	// pin sampling and condition detect
	// ----------------------------------------
	smb_sync #(.W(3)) u_sync (
		.clk(clk_link),
		.rst_b(rst_b),
		.d({bus.scl, bus.sda, power_good}),
		.q({scl_s, sda_s, pg_s})
	);

	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_seen = scl_s && scl_d && sda_d && !sda_s;
	assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
	assign ack_fall = scl_fall && (cnt == BIT_ACK);
	assign end_fall = scl_fall && (cnt == BIT_END);
	assign tx_stage = (stage == ST_TLO) || (stage == ST_THI);
	assign cur_tx = (stage == ST_THI) ? tx_word[15:8] : tx_word[7:0];
	assign wr_en = ack_fall && (stage == ST_DHI) && pg_s;

	// ----------------------------------------
	// bit framing
	// ----------------------------------------
	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 4'h0;
			shreg <= 8'h00;
		end else if (!pg_s || start_seen || stop_seen) begin
			cnt <= 4'h0;
		end else if (scl_rise && cnt <= BIT_ACK) begin
			cnt <= cnt + 4'h1;
			if (cnt < BIT_ACK) begin
				shreg <= {shreg[6:0], sda_s};
			end
		end else if (end_fall) begin
			cnt <= 4'h0;
		end
	end

	// ----------------------------------------
	// transaction sequencing and sda drive
	// ----------------------------------------
	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			stage <= ST_IDLE;
			stage_after <= ST_IDLE;
			cmd <= 8'h00;
			lo_byte <= 8'h00;
			tx_word <= 16'h0000;
			m_ack <= 1'b0;
			sda_oe <= 1'b0;
		end else if (!pg_s || stop_seen) begin
			stage <= ST_IDLE;
			sda_oe <= 1'b0;
		end else if (start_seen) begin
			stage <= ST_ADDR;
			sda_oe <= 1'b0;
		end else if (ack_fall) begin
			case (stage)
				ST_ADDR: begin
					if (shreg[7:1] == TARGET_ADDR) begin
						sda_oe <= 1'b1;
						stage_after <= shreg[0] ? ST_TLO : ST_CMD;
						tx_word <= rd_word(cmd, charger_option_control,
							battery_fill_current_setting,
							battery_target_voltage_setting,
							supply_draw_limit_setting);
					end else begin
						stage <= ST_WAIT;
					end
				end
				ST_CMD: begin
					sda_oe <= 1'b1;
					cmd <= shreg;
					stage_after <= ST_DLO;
				end
				ST_DLO: begin
					sda_oe <= 1'b1;
					lo_byte <= shreg;
					stage_after <= ST_DHI;
				end
				ST_DHI: begin
					sda_oe <= 1'b1;
					stage_after <= ST_WAIT;
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end else if (scl_rise && cnt == BIT_ACK && tx_stage) begin
			m_ack <= !sda_s;
		end else if (end_fall) begin
			case (stage)
				ST_TLO: begin
					if (m_ack) begin
						stage <= ST_THI;
						sda_oe <= !tx_word[15];
					end else begin
						stage <= ST_WAIT;
						sda_oe <= 1'b0;
					end
				end
				ST_THI: begin
					stage <= ST_WAIT;
					sda_oe <= 1'b0;
				end
				ST_IDLE, ST_WAIT: begin
					sda_oe <= 1'b0;
				end
				default: begin
					stage <= stage_after;
					sda_oe <= (stage_after == ST_TLO) ? !tx_word[7] : 1'b0;
				end
			endcase
		end else if (scl_fall && tx_stage && cnt != 4'h0 && cnt < BIT_ACK) begin
			sda_oe <= !cur_tx[3'h7 - cnt[2:0]];
		end
	end

	// ----------------------------------------
	// charger setting registers
	// ----------------------------------------
	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			charger_option_control <= RST_OPTION;
			battery_fill_current_setting <= RST_FILL;
			battery_target_voltage_setting <= RST_VOLT;
			supply_draw_limit_setting <= RST_DRAW;
		end else if (wr_en) begin
			case (cmd)
				CMD_OPTION: charger_option_control <= {shreg, lo_byte};
				CMD_FILL: battery_fill_current_setting <= {shreg, lo_byte};
				CMD_VOLT: battery_target_voltage_setting <= {shreg, lo_byte};
				CMD_DRAW: supply_draw_limit_setting <= {shreg, lo_byte};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			bus_active <= 1'b0;
		end else begin
			bus_active <= (stage != ST_IDLE);
		end
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = sda_oe;
endmodule

// *** smb_host.sv ***
// bus host issuing word reads and writes, ordered over avalon-mm
// assumes clk_sys at 200 MHz, rst_b async low, no clock stretching
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module smb_host import smb_pkg::*; #(
	parameter int QTR = SCL_QTR_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	smb_if.host bus
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} smb_hstate_e;

	smb_hstate_e hst;
	logic [15:0] qcnt;
	logic tick;
	logic [1:0] q;
	logic [3:0] bit_i;
	logic [2:0] idx;
	logic is_rd;
	logic [7:0] shin;
	logic ack_bad;
	logic [7:0] cmd_code;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic busy;
	logic nack_err;
	logic scl_oe;
	logic sda_oe;
	logic sda_s;
	logic wr_take;
	logic go;
	logic rx_byte;
	logic [7:0] txb;

	function automatic logic [7:0] tx_sel(input logic [2:0] i, input logic rd,
		input logic [7:0] c, input logic [15:0] w);
		case (i)
			3'h0: tx_sel = {TARGET_ADDR, 1'b0};
			3'h1: tx_sel = c;
			3'h2: tx_sel = rd ? {TARGET_ADDR, 1'b1} : w[7:0];
			3'h3: tx_sel = w[15:8];
			default: tx_sel = 8'hFF;
		endcase
	endfunction

	smb_sync #(.W(1)) u_sync (
		.clk(clk_sys),
		.rst_b(rst_b),
		.d(bus.sda),
		.q(sda_s)
	);

	// ----------------------------------------
	// avalon-mm slave
	// ----------------------------------------
	assign wr_take = avs_write && !avs_waitrequest;
	assign go = wr_take && (avs_address[3:2] == REG_CTRL[3:2]) && !busy
		&& (avs_writedata[CTRL_GO_WR] || avs_writedata[CTRL_GO_RD]);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
			if (avs_waitrequest && avs_read) begin
				case (avs_address[3:2])
					REG_CMD[3:2]: avs_readdata <= {24'h000000, cmd_code};
					REG_WDATA[3:2]: avs_readdata <= {16'h0000, wdata};
					REG_STATUS[3:2]: avs_readdata <= {rdata, 14'h0000, nack_err, busy};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmd_code <= 8'h00;
			wdata <= 16'h0000;
		end else if (wr_take && !busy) begin
			if (avs_address[3:2] == REG_CMD[3:2]) begin
				cmd_code <= avs_writedata[7:0];
			end
			if (avs_address[3:2] == REG_WDATA[3:2]) begin
				wdata <= avs_writedata[15:0];
			end
		end
	end

	// ----------------------------------------
	// scl quarter-period divider
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			qcnt <= 16'h0000;
		end else if (qcnt == 16'(QTR - 1)) begin
			qcnt <= 16'h0000;
		end else begin
			qcnt <= qcnt + 16'h0001;
		end
	end
	assign tick = (qcnt == 16'(QTR - 1));
	assign rx_byte = is_rd && (idx >= 3'h3);
	assign txb = tx_sel(idx, is_rd, cmd_code, wdata);

	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hst <= H_IDLE;
			q <= 2'h0;
			bit_i <= 4'h0;
			idx <= 3'h0;
			is_rd <= 1'b0;
			shin <= 8'h00;
			ack_bad <= 1'b0;
			rdata <= 16'h0000;
			busy <= 1'b0;
			nack_err <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (go) begin
			hst <= H_START;
			busy <= 1'b1;
			nack_err <= 1'b0;
			q <= 2'h0;
			idx <= 3'h0;
			is_rd <= avs_writedata[CTRL_GO_RD];
		end else if (tick && hst != H_IDLE) begin
			q <= q + 2'h1;
			case (hst)
				H_START: begin
					case (q)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b1;
						default: begin
							scl_oe <= 1'b1;
							hst <= H_BIT;
							bit_i <= 4'h0;
						end
					endcase
				end
				H_BIT: begin
					case (q)
						2'h0: begin
							if (bit_i < BIT_ACK) begin
								sda_oe <= rx_byte ? 1'b0 : !txb[3'h7 - bit_i[2:0]];
							end else begin
								sda_oe <= rx_byte && (idx == 3'h3);
							end
						end
						2'h1: scl_oe <= 1'b0;
						2'h2: begin
							if (bit_i < BIT_ACK) begin
								shin <= {shin[6:0], sda_s};
							end else begin
								ack_bad <= !rx_byte && sda_s;
							end
						end
						default: begin
							scl_oe <= 1'b1;
							if (bit_i < BIT_ACK) begin
								bit_i <= bit_i + 4'h1;
							end else if (ack_bad) begin
								nack_err <= 1'b1;
								hst <= H_STOP;
							end else if (rx_byte && idx == 3'h3) begin
								rdata[7:0] <= shin;
								idx <= 3'h4;
								bit_i <= 4'h0;
							end else if (rx_byte) begin
								rdata[15:8] <= shin;
								hst <= H_STOP;
							end else if (!is_rd && idx == 3'h3) begin
								hst <= H_STOP;
							end else if (is_rd && idx == 3'h1) begin
								idx <= 3'h2;
								hst <= H_START;
							end else begin
								idx <= idx + 3'h1;
								bit_i <= 4'h0;
							end
						end
					endcase
				end
				H_STOP: begin
					case (q)
						2'h0: sda_oe <= 1'b1;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b0;
						default: begin
							busy <= 1'b0;
							hst <= H_IDLE;
						end
					endcase
				end
				default: hst <= H_IDLE;
			endcase
		end
	end

	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_oe;
	assign bus.host_sda_oe = sda_oe;
endmodule

// *** smb_checker.sv ***
// wire checks on the two-wire bus between host and charger target
// assumes open-drain levels from smb_if, clk_link and rst_b of the target
`timescale 1ns/1ps
module smb_checker (
	input wire logic clk_link,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	// ----------------------------------------
	// scl high time and assertions
	// ----------------------------------------
	logic [7:0] high_cnt;
	always_ff @(posedge clk_link or negedge rst_b) begin
		if (!rst_b) begin
			high_cnt <= 8'h00;
		end else if (!scl) begin
			high_cnt <= 8'h00;
		end else if (high_cnt != 8'hFF) begin
			high_cnt <= high_cnt + 8'h01;
		end
	end
	default clocking cb @(posedge clk_link); endclocking
	default disable iff (!rst_b);
	chk_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target sda changed while scl high");
	chk_drive_span: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8] ##[1:300] !dev_sda_oe)
		else $error("target sda drive too short or never released");
	chk_start_quiet: assert property (($fell(sda) && scl) |-> !dev_sda_oe [*8])
		else $error("target drives sda right after start");
	chk_stop_quiet: assert property ((scl && $rose(sda)) |-> !dev_sda_oe [*8])
		else $error("target drives sda after stop");
	chk_idle_no_drive: assert property ((high_cnt > 8'h28) |-> !dev_sda_oe)
		else $error("target drives sda on idle bus");
	chk_dev_hold_high: assert property ($rose(scl) |-> $stable(dev_sda_oe) [*8])
		else $error("target sda not stable while scl high");
	chk_host_hold_high: assert property ($rose(scl) |-> $stable(host_sda_oe) [*4])
		else $error("host sda not stable after scl rise");
	chk_ack_to_rise: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:30] $rose(scl)))
		else $error("target sda released before scl rise");
endmodule

// *** smbus_charger_register_slave_tb.sv ***
// bench: host and charger target joined by smb_if, driven over avalon-mm
// assumes smb_pkg, smb_if, smb_host, smb_target and smb_checker
`timescale 1ns/1ps
module smbus_charger_register_slave_tb import smb_pkg::*;;
	// ----------------------------------------
	// clocks, design and bus monitor
	// ----------------------------------------
	localparam logic [15:0] MAKER_TB = 16'hC3E1; // arbitrary value
	localparam logic [15:0] PART_TB = 16'h2B70; // arbitrary value
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic rst_b = 1'b0;
	logic power_good = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic bus_active;
	logic [15:0] regs [4];
	logic [15:0] exp_regs [4] = '{RST_OPTION, RST_FILL, RST_VOLT, RST_DRAW};
	logic [8:0] mon_q [$];
	logic [8:0] mon_sh = 9'h0;
	int mon_n = 0;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #2.5 clk_sys = !clk_sys;
	always #24 clk_link = !clk_link;
	smb_if bus_i();
	smb_host #(.QTR(60)) u_smb_host(.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus_i.host));
	smb_target #(.MAKER_ID(MAKER_TB), .PART_ID(PART_TB)) u_smb_target(.clk_link(clk_link),
		.rst_b(rst_b), .power_good(power_good), .bus(bus_i.dev), .charger_option_control(regs[0]),
		.battery_fill_current_setting(regs[1]), .battery_target_voltage_setting(regs[2]),
		.supply_draw_limit_setting(regs[3]), .bus_active(bus_active));
	smb_checker u_smb_checker(.clk_link(clk_link), .rst_b(rst_b), .scl(bus_i.scl), .sda(bus_i.sda),
		.host_sda_oe(bus_i.host_sda_oe), .dev_sda_oe(bus_i.dev_sda_oe));
	always @(negedge bus_i.sda) if (bus_i.scl === 1'b1) mon_n = 0;
	always @(posedge bus_i.scl) begin
		mon_sh = {mon_sh[7:0], bus_i.sda};
		mon_n++;
		if (mon_n == 9) begin
			mon_q.push_back(mon_sh);
			mon_n = 0;
		end
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 99000) begin
			num_errors++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// tasks and scenarios
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp9(input string what, input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check_regs();
		for (int i = 0; i < 4; i++) cmp16("setting register", exp_regs[i], regs[i]);
	endtask
	task automatic av(input logic [3:0] a, input logic rd, input logic [31:0] wd,
		output logic [31:0] q);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= wd;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk_sys);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic smb_op(input logic rd, input logic [7:0] c, input logic [15:0] wd,
		input logic nk, input logic [15:0] er);
		logic [31:0] s;
		logic [8:0] e [$];
		logic act;
		mon_q.delete();
		av(REG_CMD, 1'b0, {24'h0, c}, s);
		av(REG_WDATA, 1'b0, {16'h0, wd}, s);
		av(REG_CMD, 1'b1, 32'h0, s);
		cmp16("command register", {8'h00, c}, s[15:0]);
		av(REG_WDATA, 1'b1, 32'h0, s);
		cmp16("word register", wd, s[15:0]);
		av(REG_CTRL, 1'b0, rd ? 32'h2 : 32'h1, s);
		act = 1'b0;
		s = 32'h1;
		while (s[STAT_BUSY] !== 1'b0) begin
			av(REG_STATUS, 1'b1, 32'h0, s);
			act = act | bus_active;
		end
		cmp9("nack flag", {8'h00, nk}, {8'h00, s[STAT_NACK]});
		cmp9("bus active busy", {8'h00, !nk}, {8'h00, act});
		if (rd && !nk) cmp16("read word", er, s[31:16]);
		e = {{TARGET_ADDR, 1'b0, nk}};
		if (!nk) begin
			e.push_back({c, 1'b0});
			if (rd) e.push_back({TARGET_ADDR, 1'b1, 1'b0});
			e.push_back({rd ? er[7:0] : wd[7:0], 1'b0});
			e.push_back({rd ? er[15:8] : wd[15:8], rd});
		end
		cmp16("byte count", 16'(e.size()), 16'(mon_q.size()));
		foreach (e[i]) cmp9("bus byte", e[i], mon_q[i]);
	endtask
	task automatic t_write_all();
		logic [7:0] c [4] = '{CMD_OPTION, CMD_FILL, CMD_VOLT, CMD_DRAW};
		logic [15:0] v [4] = '{16'hA55A, 16'h3C81, 16'h1E0F, 16'hF00D};
		for (int i = 0; i < 4; i++) begin
			smb_op(1'b0, c[i], v[i], 1'b0, 16'h0);
			exp_regs[i] = v[i];
			check_regs();
		end
		repeat (20) @(posedge clk_sys);
		cmp9("bus active", 9'h0, {8'h00, bus_active});
	endtask
	task automatic t_power();
		power_good <= 1'b0;
		repeat (100) @(posedge clk_sys);
		smb_op(1'b0, CMD_VOLT, 16'h0BAD, 1'b1, 16'h0);
		check_regs();
		power_good <= 1'b1;
		repeat (100) @(posedge clk_sys);
	endtask
	task automatic t_ro_reads();
		smb_op(1'b0, CMD_PART, 16'h1111, 1'b0, 16'h0);
		smb_op(1'b0, 8'h20, 16'h2222, 1'b0, 16'h0);
		check_regs();
		smb_op(1'b1, CMD_MAKER, 16'h0, 1'b0, MAKER_TB);
		smb_op(1'b1, CMD_PART, 16'h0, 1'b0, PART_TB);
		smb_op(1'b1, CMD_FILL, 16'h0, 1'b0, exp_regs[1]);
	endtask
	initial begin
		repeat (6) @(posedge clk_link);
		@(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_link);
		@(posedge clk_sys);
		check_regs();
		cmp9("waitrequest idle", 9'h1, {8'h00, avs_waitrequest});
		t_write_all();
		t_power();
		t_ro_reads();
		report_and_stop();
	end
endmodule
